// ==== rtl/fwp_core.sv ====
/*
  Write-protection and status logic of a serial flash device.
  Assumes the serial clock is slow enough to be sampled by sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_core
  import fwp_pkg::*;
#(
  parameter int BUSY_CYCLES = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // supply monitor, high while above threshold
  input wire logic por_ok,
  // serial pins
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic dq0_in,
  input wire logic dq2_in,
  input wire logic dq3_in,
  output logic dq1_out,
  output logic dq1_oe,
  // state view
  output logic operation_pending,
  output logic write_latch_flag,
  output logic powered_down
);
  if (BUSY_CYCLES < 1) begin : g_chk
    $error("BUSY_CYCLES must be at least 1");
  end

  localparam int CNT_W = $clog2(BUSY_CYCLES + 1);

  fwp_prot_if prot ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [1:0] edge_q;
  logic sclk_s, csn_s, di_s, wp_s, hold_s, por_s;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 6'h33;
      sync_b <= 6'h33;
    end else begin
      sync_a <= {por_ok, dq3_in, dq2_in, dq0_in, cs_n, spi_clk};
      sync_b <= sync_a;
    end
  end

  assign {por_s, hold_s, wp_s, di_s, csn_s, sclk_s} = sync_b;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_q <= 2'h3;
    end else begin
      edge_q <= {csn_s, sclk_s};
    end
  end

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  logic [2:0] region_size_field;
  logic protect_from_low_end, small_granule_select, invert_protect_region;
  logic guard_mode_low, guard_mode_high;
  logic four_line_enable, scheme_select, pin_is_reset;
  logic [7:0] status_reg_one, status_reg_two;
  logic [CNT_W-1:0] busy_cnt;
  logic reset_armed;

  logic hold_active, pin_reset;
  assign hold_active = !four_line_enable && !pin_is_reset && !hold_s && !csn_s;
  assign pin_reset = !four_line_enable && pin_is_reset && !hold_s;

  logic soft_rst;
  logic int_rst;
  assign int_rst = !por_s || pin_reset || soft_rst;

  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  assign sclk_rise = sclk_s && !edge_q[0] && !csn_s && !hold_active;
  assign sclk_fall = !sclk_s && edge_q[0] && !csn_s && !hold_active;
  assign cs_rise = csn_s && !edge_q[1];
  assign cs_fall = !csn_s && edge_q[1];

  assign status_reg_one = {guard_mode_low, small_granule_select, protect_from_low_end,
    region_size_field, write_latch_flag, operation_pending};
  assign status_reg_two = {pin_is_reset, invert_protect_region, 1'b0, scheme_select,
    2'b00, four_line_enable, guard_mode_high};

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [23:0] shift;
  logic [7:0] tx;
  logic rd_active;
  logic [7:0] next_byte;
  assign next_byte = byte_cnt == 3'h0 ? {opcode[6:0], di_s} : {shift[6:0], di_s};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      opcode <= 8'h00;
      shift <= 24'h000000;
    end else if (cs_fall || int_rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_cnt == 3'h0) begin
        opcode <= next_byte;
      end else if (byte_cnt != 3'h4) begin
        shift <= {shift[22:0], di_s};
      end
      if (bit_cnt == 3'h7 && byte_cnt != 3'h4) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // status read streams the chosen register until the frame ends
  logic read_ok;
  assign read_ok = !int_rst && !powered_down;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_active <= 1'b0;
      tx <= 8'h00;
      dq1_out <= 1'b0;
    end else if (csn_s || int_rst) begin
      rd_active <= 1'b0;
    end else if (sclk_rise && bit_cnt == 3'h7 && byte_cnt == 3'h0 && read_ok) begin
      rd_active <= next_byte == status_one_read_cmd || next_byte == status_two_read_cmd;
      tx <= next_byte == status_two_read_cmd ? status_reg_two : status_reg_one;
    end else if (sclk_fall && rd_active) begin
      dq1_out <= tx[7];
      tx <= {tx[6:0], tx[7]};
    end
  end
  assign dq1_oe = rd_active && !csn_s && !hold_active;

  // ----------------------------------------------------------------
  // frame decode, taken at chip-select release
  // ----------------------------------------------------------------
  logic frame_done, accept;
  logic is_prog, is_erase, is_chip, is_sr_write;
  logic sr_write_ok, array_ok;
  assign frame_done = cs_rise && bit_cnt == 3'h0 && byte_cnt != 3'h0;
  assign accept = frame_done && !int_rst && !operation_pending &&
    (!powered_down || opcode == wake_cmd);
  assign is_prog = opcode == page_prog_cmd || opcode == quad_prog_cmd;
  assign is_erase = opcode == sector_erase_cmd || opcode == block_erase_cmd;
  assign is_chip = opcode == chip_erase_cmd;
  assign is_sr_write = (opcode == status_write_cmd && byte_cnt >= 3'h2) ||
    (opcode == status_two_write_cmd && byte_cnt == 3'h2);

  always_comb begin
    case ({guard_mode_high, guard_mode_low})
      GUARD_HW: sr_write_ok = write_latch_flag && (wp_s || four_line_enable);
      GUARD_LOCKDOWN: sr_write_ok = 1'b0;
      GUARD_OTP: sr_write_ok = 1'b0;
      default: sr_write_ok = write_latch_flag;
    endcase
  end

  assign array_ok = write_latch_flag && (byte_cnt == 3'h4 || is_chip) &&
    !(is_chip ? prot.any_protected : prot.target_protected);

  logic start_sr, start_arr, do_unlock;
  assign start_sr = accept && is_sr_write && sr_write_ok;
  assign start_arr = accept && (is_prog || is_erase || is_chip) && array_ok;
  assign do_unlock = accept && opcode == unlock_cmd && byte_cnt == 3'h4 &&
    write_latch_flag;

  assign prot.addr = shift;
  assign prot.whole_block = opcode == block_erase_cmd;
  assign prot.unlock = do_unlock;
  assign prot.relock_all = int_rst;
  assign prot.region_size_field = region_size_field;
  assign prot.protect_from_low_end = protect_from_low_end;
  assign prot.small_granule_select = small_granule_select;
  assign prot.invert_protect_region = invert_protect_region;
  assign prot.scheme_select = scheme_select;

  fwp_prot_chk u_chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .p(prot)
  );

  // ----------------------------------------------------------------
  // write latch
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_latch_flag <= 1'b0;
    end else if (int_rst) begin
      write_latch_flag <= 1'b0;
    end else if (start_sr || start_arr || do_unlock) begin
      write_latch_flag <= 1'b0;
    end else if (accept && opcode == write_forbid_cmd) begin
      write_latch_flag <= 1'b0;
    end else if (accept && opcode == write_allow_cmd) begin
      write_latch_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // busy timer; the array itself is not modelled
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= '0;
      operation_pending <= 1'b0;
    end else if (int_rst) begin
      busy_cnt <= '0;
      operation_pending <= 1'b0;
    end else if (start_sr || start_arr) begin
      busy_cnt <= CNT_W'(BUSY_CYCLES);
      operation_pending <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - 1'b1;
      operation_pending <= busy_cnt != CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // non-volatile fields: kept across internal resets, except a lockdown guard mode, which clears on supply loss
  // ----------------------------------------------------------------
  logic [7:0] wr_one, wr_two;
  assign wr_one = byte_cnt >= 3'h3 ? shift[15:8] : shift[7:0];
  assign wr_two = opcode == status_two_write_cmd ? shift[7:0] : shift[7:0];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {guard_mode_low, small_granule_select, protect_from_low_end} <= 3'h0;
      region_size_field <= STATUS_RESET[4:2];
      {guard_mode_high, four_line_enable, scheme_select} <= 3'h0;
      {invert_protect_region, pin_is_reset} <= 2'h0;
    end else if (!por_s) begin
      if ({guard_mode_high, guard_mode_low} == GUARD_LOCKDOWN) begin
        {guard_mode_high, guard_mode_low} <= 2'h0;
      end
    end else if (start_sr) begin
      if (opcode == status_write_cmd) begin
        region_size_field <= wr_one[BIT_SIZE_LO+2:BIT_SIZE_LO];
        protect_from_low_end <= wr_one[BIT_LOW_END];
        small_granule_select <= wr_one[BIT_GRANULE];
        guard_mode_low <= wr_one[BIT_GUARD_LO];
      end
      if (opcode == status_two_write_cmd || byte_cnt >= 3'h3) begin
        guard_mode_high <= wr_two[BIT_GUARD_HI];
        four_line_enable <= wr_two[BIT_FOUR_LINE];
        scheme_select <= wr_two[BIT_SCHEME];
        invert_protect_region <= wr_two[BIT_INVERT];
        pin_is_reset <= wr_two[BIT_PIN_FUNC];
      end
    end
  end

  // ----------------------------------------------------------------
  // power-down and software reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powered_down <= 1'b0;
      reset_armed <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (int_rst) begin
        powered_down <= 1'b0;
        reset_armed <= 1'b0;
      end else if (accept) begin
        reset_armed <= opcode == reset_arm_cmd;
        if (opcode == sleep_cmd) begin
          powered_down <= 1'b1;
        end else if (opcode == wake_cmd) begin
          powered_down <= 1'b0;
        end
        if (opcode == reset_go_cmd && reset_armed) begin
          soft_rst <= 1'b1;
        end
      end
    end
  end
endmodule // fwp_core
`default_nettype wire

// ==== rtl/fwp_pkg.sv ====
/*
  Shared constants for the flash write-protect and status block:
  opcodes, status bit positions, lock array layout.
  Assumes 24-bit byte addresses, 64KB blocks, 4KB sectors.
*/
package fwp_pkg;
  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] write_allow_cmd = 8'h06;
  localparam logic [7:0] write_forbid_cmd = 8'h04;
  localparam logic [7:0] status_one_read_cmd = 8'h05;
  localparam logic [7:0] status_two_read_cmd = 8'h35;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] status_two_write_cmd = 8'h31;
  localparam logic [7:0] unlock_cmd = 8'h39;
  localparam logic [7:0] page_prog_cmd = 8'h02;
  localparam logic [7:0] quad_prog_cmd = 8'h32;
  localparam logic [7:0] sector_erase_cmd = 8'h20;
  localparam logic [7:0] block_erase_cmd = 8'hD8;
  localparam logic [7:0] chip_erase_cmd = 8'hC7;
  localparam logic [7:0] sleep_cmd = 8'hB9;
  localparam logic [7:0] wake_cmd = 8'hAB;
  localparam logic [7:0] reset_arm_cmd = 8'h66;
  localparam logic [7:0] reset_go_cmd = 8'h99;
  localparam logic [7:0] suspend_cmd = 8'h75;

  // ----------------------------------------------------------------
  // status register one (byte 0) and two (byte 1) bit positions
  // ----------------------------------------------------------------
  localparam int BIT_PENDING = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_SIZE_LO = 2;
  localparam int BIT_LOW_END = 5;
  localparam int BIT_GRANULE = 6;
  localparam int BIT_GUARD_LO = 7;
  localparam int BIT_GUARD_HI = 0;
  localparam int BIT_FOUR_LINE = 1;
  localparam int BIT_SCHEME = 4;
  localparam int BIT_INVERT = 6;
  localparam int BIT_PIN_FUNC = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // individual lock layout: 16 + 16 sectors, then 254 inner blocks
  // ----------------------------------------------------------------
  localparam int SECTORS_PER_END = 16;
  localparam int INNER_BLOCKS = 254;
  localparam int LOCK_COUNT = 2 * SECTORS_PER_END + INNER_BLOCKS;
  localparam int LOCK_W = 9;
  localparam logic [7:0] TOP_BLOCK = 8'hFF;
  localparam logic [2:0] SIZE_ALL = 3'h7;
  localparam logic [1:0] GUARD_HW = 2'h1;
  localparam logic [1:0] GUARD_LOCKDOWN = 2'h2;
  localparam logic [1:0] GUARD_OTP = 2'h3;
endpackage

// ==== rtl/fwp_prot_if.sv ====
/*
  Carrier between the command core and the protection checker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fwp_prot_if;
  logic [23:0] addr;
  logic whole_block;
  logic unlock;
  logic relock_all;
  logic [2:0] region_size_field;
  logic protect_from_low_end;
  logic small_granule_select;
  logic invert_protect_region;
  logic scheme_select;
  logic target_protected;
  logic any_protected;
  modport core (output addr, whole_block, unlock, relock_all, region_size_field,
    protect_from_low_end, small_granule_select, invert_protect_region, scheme_select,
    input target_protected, any_protected);
  modport chk (input addr, whole_block, unlock, relock_all, region_size_field,
    protect_from_low_end, small_granule_select, invert_protect_region, scheme_select,
    output target_protected, any_protected);
endinterface
`default_nettype wire

// ==== rtl/fwp_prot_chk.sv ====
/*
  Individual lock bits and region protection decision.
  Assumes unlock is a one-cycle pulse from the core; relock_all is held for as long as the internal reset lasts.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_prot_chk
  import fwp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // core side
  fwp_prot_if.chk p
);
  logic [LOCK_COUNT-1:0] locks;
  logic [7:0] blk;
  logic [3:0] sec;
  logic [LOCK_W-1:0] idx;
  logic lock_hit;
  logic [23:0] mask;
  logic [4:0] keep;
  logic region_hit;
  logic scheme0_any;

  assign blk = p.addr[23:16];
  assign sec = p.addr[15:12];

  always_comb begin
    if (blk == 8'h00) begin
      idx = LOCK_W'(sec);
    end else if (blk == TOP_BLOCK) begin
      idx = LOCK_W'(SECTORS_PER_END) + LOCK_W'(sec);
    end else begin
      idx = LOCK_W'(2 * SECTORS_PER_END - 1) + LOCK_W'(blk);
    end
  end

  // ----------------------------------------------------------------
  // lock storage: all set at power-on, cleared one at a time
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      locks <= '1;
    end else if (p.relock_all) begin
      locks <= '1;
    end else if (p.unlock) begin
      locks[idx] <= 1'b0;
    end
  end

  // erasing an end block touches all 16 of its sector locks
  always_comb begin
    lock_hit = locks[idx];
    if (p.whole_block && (blk == 8'h00)) begin
      lock_hit = |locks[SECTORS_PER_END-1:0];
    end else if (p.whole_block && (blk == TOP_BLOCK)) begin
      lock_hit = |locks[2*SECTORS_PER_END-1:SECTORS_PER_END];
    end
  end

  // protected span is a power-of-two slice at one end of the array
  always_comb begin
    if (p.small_granule_select) begin
      keep = (p.region_size_field >= 3'h4) ? 5'd9 : 5'd13 - 5'(p.region_size_field);
    end else begin
      keep = 5'd7 - 5'(p.region_size_field);
    end
    mask = 24'hFFFFFF << (5'd24 - keep);
    if (p.protect_from_low_end) begin
      region_hit = (p.addr & mask) == 24'h000000;
    end else begin
      region_hit = (p.addr & mask) == mask;
    end
    if (p.region_size_field == SIZE_ALL && !p.small_granule_select) begin
      region_hit = 1'b1;
    end
    if (p.region_size_field == 3'h0) begin
      region_hit = 1'b0;
    end
  end

  assign scheme0_any = p.invert_protect_region ?
    !(p.region_size_field == SIZE_ALL && !p.small_granule_select) :
    (p.region_size_field != 3'h0);

  assign p.target_protected = p.scheme_select ? lock_hit :
    (region_hit ^ p.invert_protect_region);
  assign p.any_protected = p.scheme_select ? (|locks) : scheme0_any;
endmodule // fwp_prot_chk
`default_nettype wire

// ==== verification/fwp_core_chk.sv ====
/*
  Port-level checker for fwp_core, attached by bind.
  Assumes the busy time is exactly BUSY_CYCLES clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_core_chk #(
  parameter int BUSY_CYCLES = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // inputs
  input wire logic por_ok,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic dq0_in,
  input wire logic dq2_in,
  input wire logic dq3_in,
  // outputs
  input wire logic dq1_out,
  input wire logic dq1_oe,
  input wire logic operation_pending,
  input wire logic write_latch_flag,
  input wire logic powered_down
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // busy length counter
  // ------------------------------------------------------------
  int busy_cnt;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      busy_cnt <= 0;
    else
      busy_cnt <= operation_pending ? busy_cnt + 1 : 0;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_por_clear;
    !por_ok [*5] |-> !write_latch_flag && !operation_pending && !powered_down;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("flags set under low supply");
  property p_rst_clear;
    $fell(sys_rst) |-> !write_latch_flag && !operation_pending && !powered_down;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("flags set after reset");
  property p_latch_set;
    $rose(write_latch_flag) |-> !$past(operation_pending) && !$past(powered_down);
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set while busy or asleep");
  property p_busy_start;
    $rose(operation_pending) |-> !write_latch_flag && $past(write_latch_flag, 2);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without latch handover");
  property p_busy_max;
    busy_cnt <= BUSY_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_len;
    $fell(operation_pending) |-> busy_cnt == BUSY_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_sleep_enter;
    $rose(powered_down) |-> !$past(operation_pending) && $past(cs_n);
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entered while busy");
  // commands act only at the end of a frame, never mid-frame
  property p_exec_cs;
    !cs_n [*6] |-> !$rose(write_latch_flag) && !$rose(operation_pending) && !$rose(powered_down);
  endproperty
  a_exec_cs: assert property (p_exec_cs) else $error("flag changed inside a frame");
  c_busy: cover property ($rose(operation_pending));
  c_sleep: cover property ($rose(powered_down));
  c_latch_off: cover property ($fell(write_latch_flag) && !operation_pending);
endmodule // fwp_core_chk

bind fwp_core fwp_core_chk #(.BUSY_CYCLES(BUSY_CYCLES)) u_core_chk (.sys_clk, .sys_rst, .por_ok,
  .spi_clk, .cs_n, .dq0_in, .dq2_in, .dq3_in, .dq1_out, .dq1_oe, .operation_pending,
  .write_latch_flag, .powered_down);
`default_nettype wire

// ==== verification/fwp_host_model.sv ====
/*
  Serial host model: mode 0 frames, 80 ns link clock, MSB first.
  Assumes the caller starts frames only from the bench thread.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic spi_clk,
  output logic cs_n,
  output logic dq0_in,
  input wire logic dq1_out
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    dq0_in = 1'b0;
  end
  // rd keeps the last eight bits seen on the answer line
  task automatic frame(input logic [7:0] q[$], output logic [7:0] rd);
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        dq0_in = q[i][b];
        #40 spi_clk = 1'b1;
        rd = {rd[6:0], dq1_out};
        #40 spi_clk = 1'b0;
      end
    end
    #40 cs_n = 1'b1;
    // idle data line must not keep the last bit
    dq0_in = ~dq0_in;
    repeat (12) @(posedge sys_clk);
    #1;
  endtask
endmodule // fwp_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench for fwp_core with a serial host model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, sys_rst, por_ok, dq2_in, dq3_in, spi_clk, cs_n, dq0_in;
  logic dq1_out, dq1_oe, operation_pending, write_latch_flag, powered_down;
  logic [7:0] rd;
  int fail_count = 0;
  int samples_checked = 0;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  fwp_core #(.BUSY_CYCLES(300)) dut (.sys_clk, .sys_rst, .por_ok, .spi_clk, .cs_n, .dq0_in,
    .dq2_in, .dq3_in, .dq1_out, .dq1_oe, .operation_pending, .write_latch_flag, .powered_down);
  // an undriven answer line reads inverted, so a missing enable shows up
  fwp_host_model host (.sys_clk, .spi_clk, .cs_n, .dq0_in,
    .dq1_out(dq1_oe ? dq1_out : !dq1_out));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // exp is {asleep, busy, latch}
  task automatic flags(input logic [2:0] exp);
    cmp("flags", {5'h00, exp}, {5'h00, powered_down, operation_pending, write_latch_flag});
  endtask
  task automatic go(input logic [7:0] q[$]);
    host.frame(q, rd);
  endtask
  task automatic sread(input logic [7:0] c, input logic [7:0] exp);
    host.frame('{c, 8'h00}, rd);
    cmp("status", exp, rd);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (operation_pending !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp("busy end", 8'h00, {7'h00, operation_pending});
  endtask
  task automatic wsr(input logic [7:0] q[$]);
    go('{8'h06});
    go(q);
    idle();
  endtask
  task automatic pin(input int which);
    @(posedge sys_clk);
    #1;
    if (which == 0)
      por_ok = 1'b0;
    else
      dq3_in = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 por_ok = 1'b1;
    dq3_in = 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_latch();
    flags(3'b000);
    sread(8'h05, 8'h00);
    sread(8'h35, 8'h00);
    go('{8'h06});
    flags(3'b001);
    sread(8'h05, 8'h02);
    go('{8'h04});
    flags(3'b000);
  endtask
  task automatic t_busy();
    go('{8'h06});
    go('{8'h01, 8'h1C});
    flags(3'b010);
    sread(8'h05, 8'h1D);
    go('{8'h06});
    flags(3'b010);
    idle();
    sread(8'h05, 8'h1C);
  endtask
  task automatic t_protect();
    wsr('{8'h01, 8'h24});
    go('{8'h06});
    go('{8'h02, 8'h00, 8'h00, 8'h00, 8'hA5});
    flags(3'b001);
    go('{8'h02, 8'hFF, 8'hF0, 8'h00, 8'hA5});
    flags(3'b010);
    idle();
    wsr('{8'h01, 8'h1C, 8'h40});
    go('{8'h06});
    go('{8'h02, 8'h00, 8'h00, 8'h00, 8'hA5});
    flags(3'b010);
    idle();
    wsr('{8'h01, 8'h00, 8'h00});
  endtask
  task automatic t_locks();
    wsr('{8'h31, 8'h10});
    sread(8'h35, 8'h10);
    go('{8'h06});
    go('{8'h20, 8'h10, 8'h00, 8'h00});
    flags(3'b001);
    go('{8'h39, 8'h10, 8'h00, 8'h00});
    flags(3'b000);
    go('{8'h06});
    go('{8'h20, 8'h10, 8'h00, 8'h00});
    flags(3'b010);
    idle();
    go('{8'h06});
    go('{8'h66});
    go('{8'h99});
    flags(3'b000);
    go('{8'h06});
    go('{8'h20, 8'h10, 8'h00, 8'h00});
    flags(3'b001);
    wsr('{8'h31, 8'h00});
  endtask
  task automatic t_power();
    go('{8'hB9});
    flags(3'b100);
    go('{8'h06});
    flags(3'b100);
    go('{8'hAB});
    flags(3'b000);
    wsr('{8'h31, 8'h80});
    go('{8'h06});
    pin(1);
    flags(3'b000);
    go('{8'h06});
    pin(0);
    flags(3'b000);
    sread(8'h35, 8'h80);
    wsr('{8'h31, 8'h00});
  endtask
  task automatic t_guard();
    wsr('{8'h01, 8'h80});
    wsr('{8'h01, 8'h84});
    sread(8'h05, 8'h82);
    dq2_in = 1'b1;
    wsr('{8'h01, 8'h80, 8'h02});
    dq2_in = 1'b0;
    wsr('{8'h01, 8'h84, 8'h02});
    sread(8'h05, 8'h84);
    wsr('{8'h01, 8'h00, 8'h01});
    sread(8'h35, 8'h01);
    wsr('{8'h01, 8'h00, 8'h00});
    sread(8'h35, 8'h01);
    pin(0);
    sread(8'h35, 8'h00);
    wsr('{8'h01, 8'h80, 8'h01});
    wsr('{8'h01, 8'h00, 8'h00});
    sread(8'h05, 8'h82);
  endtask
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    por_ok = 1'b1;
    dq2_in = 1'b0;
    dq3_in = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    t_latch();
    t_busy();
    t_protect();
    t_locks();
    t_power();
    t_guard();
    give_verdict();
  end
  // about six times the expected run length
  initial begin
    #900000;
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
